// ### design/pec_consts.svh
// Purpose: offsets, field positions and reset values of the performance event counters
// Assumes: word index = byte address / 4, apb address 12 bits
// Notes:   definitions only
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// word indices of the counter low words
`define PEC_IDX_CTR0        10'h309
`define PEC_IDX_CTR1        10'h30a
`define PEC_IDX_CTR2        10'h30b
// high word index = low word index + this
`define PEC_IDX_HI_OFS      10'h040
// control and general-purpose counter words
`define PEC_IDX_FIXED_EN    10'h380
`define PEC_IDX_EVTSEL      10'h381
`define PEC_IDX_GP_LO       10'h382
`define PEC_IDX_GP_HI       10'h383

// event select register fields
`define PEC_EVTSEL_EVT_LSB  0
`define PEC_EVTSEL_UM_LSB   8
`define PEC_EVTSEL_EN_BIT   22

// event encodings
`define PEC_EVT_INST_RET    8'hc0
`define PEC_UM_RET_ANY      8'h00
`define PEC_UM_RET_VROOT    8'h08
`define PEC_EVT_LOAD_BLOCK  8'h03
`define PEC_UM_LB_ADDR      8'h02
`define PEC_UM_LB_DATA      8'h04
`define PEC_UM_LB_OVERLAP   8'h08
`define PEC_EVT_RENAME_STL  8'hd2
`define PEC_UM_RN_SERIAL    8'h10

// reset values
`define PEC_RST_FIXED_EN    3'h7
`define PEC_RST_COUNT       64'h0000_0000_0000_0000
`define PEC_RST_WORD        32'h0000_0000

`endif

// ### design/pec_pkg.sv
// Purpose: shared types of the performance event counters
// Assumes: constants come from pec_consts.svh
// Notes:   types only
package pec_pkg;

	typedef struct packed
	{
		logic       en;
		logic [7:0] umask;
		logic [7:0] event_sel;
	} pec_evtsel_s;

	// per-cycle event indications from pipeline, retirement and power-state logic
	typedef struct packed
	{
		logic inst_retire;              // final micro-op of an instruction retires
		logic in_virt_root;             // virtualization_extension root operation
		logic halted_by_halt_instruction;
		logic halted_by_monitor_wait_instruction;
		logic thermal_monitor_stop_clk;
		logic ref_tick;                 // one pulse per time-stamp-counter increment
		logic load_blocked_store_address_event;
		logic load_blocked_store_value_event;
		logic load_partial_overlap;
		logic load_small_misaligned;
		logic load_wide_misaligned;
		logic register_rename_table_serial_stall;
	} pec_core_evt_s;

	typedef struct packed
	{
		logic [63:0] count;
	} pec_cnt_state_s;

	typedef struct packed
	{
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [2:0]  fixed_en;
		pec_evtsel_s evtsel;
	} pec_top_state_s;

endpackage

// ### design/pec_counter64.sv
// Purpose: one 64-bit event counter with word-wise software load
// Assumes: inc_i is at most one event per clock
// Notes:   a software write wins over an increment in the same cycle in the written word only; the other word keeps the increment
`timescale 1ns/1ps
`default_nettype none
`include "pec_consts.svh"

module pec_counter64
	import pec_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        inc_i,
	input  wire logic        wr_lo_i,
	input  wire logic        wr_hi_i,
	input  wire logic [31:0] wdata_i,
	output logic      [63:0] count_o
);

	pec_cnt_state_s state_reg;
	pec_cnt_state_s state_next;

	always_comb
	begin
		state_next = state_reg;
		if (inc_i)
		begin
			state_next.count = state_reg.count + 64'h1;
		end
		// loading software value; the written word drops the counted event of this cycle, an unwritten word keeps it
		if (wr_lo_i)
		begin
			state_next.count[31:0] = wdata_i;
		end
		if (wr_hi_i)
		begin
			state_next.count[63:32] = wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			state_reg.count <= `PEC_RST_COUNT;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign count_o = state_reg.count;

endmodule // pec_counter64

`default_nettype wire

// ### design/pec_event_qual.sv
// Purpose: qualifies core events against the general-purpose event select
// Assumes: event inputs are per-cycle levels on clk_sys_i
// Notes:   combinational; unknown event codes never count, undefined load-block unit mask bits are ignored
`timescale 1ns/1ps
`default_nettype none
`include "pec_consts.svh"

module pec_event_qual
	import pec_pkg::*;
(
	input  wire pec_evtsel_s   evtsel_i,
	input  wire pec_core_evt_s evt_i,
	output logic               hit_o
);

	logic overlap_store;

	// partial overlap and both misaligned forwarding cases share one unit mask
	assign overlap_store = evt_i.load_partial_overlap
		| evt_i.load_small_misaligned
		| evt_i.load_wide_misaligned;

	always_comb
	begin
		hit_o = 1'b0;
		case (evtsel_i.event_sel)
			`PEC_EVT_INST_RET:
			begin
				if (evtsel_i.umask == `PEC_UM_RET_VROOT)
				begin
					hit_o = evt_i.inst_retire & evt_i.in_virt_root;
				end
				else if (evtsel_i.umask == `PEC_UM_RET_ANY)
				begin
					hit_o = evt_i.inst_retire;
				end
			end
			`PEC_EVT_LOAD_BLOCK:
			begin
				// several unit mask bits count the union; a load blocked over
				// several cycles is counted again each cycle, so never under
				hit_o = ((|(evtsel_i.umask & `PEC_UM_LB_ADDR)) & evt_i.load_blocked_store_address_event)
					| ((|(evtsel_i.umask & `PEC_UM_LB_DATA)) & evt_i.load_blocked_store_value_event)
					| ((|(evtsel_i.umask & `PEC_UM_LB_OVERLAP)) & overlap_store);
			end
			`PEC_EVT_RENAME_STL:
			begin
				if (evtsel_i.umask == `PEC_UM_RN_SERIAL)
				begin
					hit_o = evt_i.register_rename_table_serial_stall;
				end
			end
			default:
			begin
				hit_o = 1'b0;
			end
		endcase
	end

endmodule // pec_event_qual

`default_nettype wire

// ### design/pec_top.sv
// Purpose: fixed-function and one general-purpose performance counter behind an apb slave
// Assumes: core event inputs are synchronous to clk_sys_i; ref_tick pulses at tsc rate
// Notes:   read data is sampled in the apb setup cycle; one wait-free access phase
`timescale 1ns/1ps
`default_nettype none
`include "pec_consts.svh"

module pec_top
	import pec_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          nrst_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	input  wire logic [3:0]    pstrb_i,
	output logic               pready_o,
	output logic               pslverr_o,
	output logic      [31:0]   prdata_o,
	input  wire pec_core_evt_s core_evt_i
);

	localparam int NCNT = 4;

	// low word index per counter: three fixed, then the general-purpose one
	localparam logic [9:0] LO_IDX [NCNT] = '{`PEC_IDX_CTR0, `PEC_IDX_CTR1, `PEC_IDX_CTR2, `PEC_IDX_GP_LO};
	localparam logic [9:0] HI_IDX [NCNT] = '{`PEC_IDX_CTR0 + `PEC_IDX_HI_OFS, `PEC_IDX_CTR1 + `PEC_IDX_HI_OFS,
		`PEC_IDX_CTR2 + `PEC_IDX_HI_OFS, `PEC_IDX_GP_HI};

	pec_top_state_s state_reg;
	pec_top_state_s state_next;

	logic [63:0]     count    [NCNT];
	logic [NCNT-1:0] inc;
	logic [NCNT-1:0] wr_lo;
	logic [NCNT-1:0] wr_hi;
	logic            wr_take;
	logic            setup;
	logic            gp_hit;
	logic            in_halt;

	function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
		idx_hit = (addr[11:2] == idx);
	endfunction

	function automatic logic idx_known(input logic [11:0] addr);
		logic k;
		k = idx_hit(addr, `PEC_IDX_FIXED_EN) | idx_hit(addr, `PEC_IDX_EVTSEL);
		for (int i = 0; i < NCNT; i++)
		begin
			k = k | idx_hit(addr, LO_IDX[i]) | idx_hit(addr, HI_IDX[i]);
		end
		idx_known = k;
	endfunction

	// write takes effect only at the completing edge of the access phase
	assign setup   = psel_i & ~penable_i;
	assign wr_take = psel_i & penable_i & pwrite_i & state_reg.pready & ~state_reg.pslverr;

	// either halting instruction puts the core in the halt state
	assign in_halt = core_evt_i.halted_by_halt_instruction | core_evt_i.halted_by_monitor_wait_instruction;

	// no interrupt or trap input gates the retire count: it is never suspended
	assign inc[0] = state_reg.fixed_en[0] & core_evt_i.inst_retire;
	assign inc[1] = state_reg.fixed_en[1] & ~in_halt;
	// ref_tick comes from the tsc divider, so p-state changes leave the rate alone
	assign inc[2] = state_reg.fixed_en[2] & core_evt_i.ref_tick
		& ~in_halt & ~core_evt_i.thermal_monitor_stop_clk;
	// model-specific events reach only the general-purpose counter
	assign inc[3] = state_reg.evtsel.en & gp_hit;

	pec_event_qual u_event_qual
	(
		.evtsel_i (state_reg.evtsel),
		.evt_i    (core_evt_i),
		.hit_o    (gp_hit)
	);

	genvar g;
	generate
		for (g = 0; g < NCNT; g++)
		begin : g_cnt
			assign wr_lo[g] = wr_take & idx_hit(paddr_i, LO_IDX[g]);
			assign wr_hi[g] = wr_take & idx_hit(paddr_i, HI_IDX[g]);

			pec_counter64 u_counter
			(
				.clk_sys_i (clk_sys_i),
				.nrst_i    (nrst_i),
				.inc_i     (inc[g]),
				.wr_lo_i   (wr_lo[g]),
				.wr_hi_i   (wr_hi[g]),
				.wdata_i   (pwdata_i),
				.count_o   (count[g])
			);
		end
	endgenerate

	always_comb
	begin
		state_next = state_reg;
		// answer is armed in the setup cycle and stands for exactly the access cycle
		state_next.pready  = setup;
		state_next.pslverr = setup & ~idx_known(paddr_i);
		if (setup)
		begin
			state_next.prdata = `PEC_RST_WORD;
			if (!pwrite_i)
			begin
				// counters are readable at any moment, without stopping them
				for (int i = 0; i < NCNT; i++)
				begin
					if (idx_hit(paddr_i, LO_IDX[i]))
					begin
						state_next.prdata = count[i][31:0];
					end
					if (idx_hit(paddr_i, HI_IDX[i]))
					begin
						state_next.prdata = count[i][63:32];
					end
				end
				if (idx_hit(paddr_i, `PEC_IDX_FIXED_EN))
				begin
					state_next.prdata = {29'h0000_0000, state_reg.fixed_en};
				end
				if (idx_hit(paddr_i, `PEC_IDX_EVTSEL))
				begin
					state_next.prdata = {9'h000, state_reg.evtsel.en, 6'h00,
						state_reg.evtsel.umask, state_reg.evtsel.event_sel};
				end
			end
		end
		else
		begin
			// read data stands only with pready, so it clears at the access edge
			state_next.prdata = `PEC_RST_WORD;
		end
		if (wr_take & idx_hit(paddr_i, `PEC_IDX_FIXED_EN))
		begin
			state_next.fixed_en = pwdata_i[2:0];
		end
		if (wr_take & idx_hit(paddr_i, `PEC_IDX_EVTSEL))
		begin
			state_next.evtsel.event_sel = pwdata_i[`PEC_EVTSEL_EVT_LSB +: 8];
			state_next.evtsel.umask     = pwdata_i[`PEC_EVTSEL_UM_LSB +: 8];
			state_next.evtsel.en        = pwdata_i[`PEC_EVTSEL_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			state_reg.pready    <= 1'b0;
			state_reg.pslverr   <= 1'b0;
			state_reg.prdata    <= `PEC_RST_WORD;
			state_reg.fixed_en  <= `PEC_RST_FIXED_EN;
			state_reg.evtsel    <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign pready_o  = state_reg.pready;
	assign pslverr_o = state_reg.pslverr;
	assign prdata_o  = state_reg.prdata;

	// byte strobes are accepted but every write is a full word
	logic unused_strb;
	assign unused_strb = ^pstrb_i;

endmodule // pec_top

`default_nettype wire

// ### verification/pec_apb_assertions.sv
// Purpose: apb handshake checks on the pec_top ports
// Assumes: one wait-free access phase per transfer
// Notes:   counter values are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module pec_apb_chk
	import pec_pkg::*;
(
	input wire logic          clk_sys_i,
	input wire logic          nrst_i,
	input wire logic          psel_i,
	input wire logic          penable_i,
	input wire logic          pwrite_i,
	input wire logic [11:0]   paddr_i,
	input wire logic [31:0]   pwdata_i,
	input wire logic [3:0]    pstrb_i,
	input wire logic          pready_o,
	input wire logic          pslverr_o,
	input wire logic [31:0]   prdata_o,
	input wire pec_core_evt_s core_evt_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_access; psel_i && penable_i; endsequence
	property p_answer; s_setup |=> pready_o; endproperty
	property p_pulse; pready_o |=> !pready_o; endproperty
	property p_in_access; pready_o |-> s_access; endproperty
	property p_err_pair; pslverr_o |-> pready_o; endproperty
	property p_idle_data; !pready_o |-> prdata_o == 32'h0; endproperty
	property p_unmapped; s_setup ##0 paddr_i < 12'hc00 |=> pslverr_o && prdata_o == 32'h0; endproperty
	property p_mapped; s_setup ##0 paddr_i[11:2] == 10'h309 |=> !pslverr_o; endproperty
	property p_reset; $rose(nrst_i) |-> !pready_o && !pslverr_o; endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	a_in_access: assert property (p_in_access) else $error("ready outside access");
	a_err_pair: assert property (p_err_pair) else $error("error without ready");
	a_idle_data: assert property (p_idle_data) else $error("read data not cleared");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	a_mapped: assert property (p_mapped) else $error("counter word refused");
	a_reset: assert property (p_reset) else $error("apb outputs live at reset");
endmodule // pec_apb_chk
bind pec_top pec_apb_chk u_pec_apb_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .core_evt_i(core_evt_i));
`default_nettype wire

// ### verification/pec_core_model.sv
// Purpose: core-side event source for the counter bench
// Assumes: random words come from the bench
// Notes:   parks halted when idle so cycle counters freeze while read
`timescale 1ns/1ps
`default_nettype none
module pec_core_model
	import pec_pkg::*;
(
	input  wire logic [11:0] rnd_i,
	input  wire logic        clk_sys_i,
	input  wire logic        act_i,
	output var pec_core_evt_s evt_o
);
	always_ff @(posedge clk_sys_i)
	begin
		if (act_i)
			evt_o <= pec_core_evt_s'(rnd_i);
		else
			evt_o <= pec_core_evt_s'(12'h200);
	end
endmodule // pec_core_model
`default_nettype wire

// ### verification/performance_event_counters_bench.sv
// Purpose: self-checking bench of the performance event counters
// Assumes: apb answers in one access cycle
// Notes:   reads happen only while the core side idles, so no read races an increment
`timescale 1ns/1ps
`default_nettype none
module performance_event_counters_bench;
	import pec_pkg::*;
	logic          clk_sys_i, nrst_i, psel, pen, pwr, act, rdy, err, er, msel, hl;
	logic [11:0]   padr, rnd;
	logic [31:0]   pwd, prd, rd;
	logic [15:0]   lfsr;
	logic [63:0]   got;
	logic [63:0]   m [4];
	logic [2:0]    men;
	logic [7:0]    mevt, mum;
	pec_core_evt_s ev;
	int            fails, n_checks;
	logic [15:0]   tbl [8] = '{16'hc000, 16'hc008, 16'h0302, 16'h0304, 16'h0308, 16'hd210, 16'h0301, 16'h030e};
	pec_top u_pec_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hf), .pready_o(rdy), .pslverr_o(err), .prdata_o(prd),
		.core_evt_i(ev));
	pec_core_model u_pec_core_model (.rnd_i(rnd), .clk_sys_i(clk_sys_i), .act_i(act), .evt_o(ev));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic gp_hit(input logic [7:0] e, input logic [7:0] u, input pec_core_evt_s c);
		if (e == 8'hc0 && u == 8'h00)
			return c.inst_retire;
		if (e == 8'hc0 && u == 8'h08)
			return c.inst_retire & c.in_virt_root;
		if (e == 8'hd2 && u == 8'h10)
			return c.register_rename_table_serial_stall;
		if (e != 8'h03)
			return 1'b0;
		return (u[1] & c.load_blocked_store_address_event) | (u[2] & c.load_blocked_store_value_event)
			| (u[3] & (c.load_partial_overlap | c.load_small_misaligned | c.load_wide_misaligned));
	endfunction
	function automatic logic [11:0] ad(input int i, input logic h);
		if (i == 3)
			return h ? 12'he0c : 12'he08;
		return 12'hc24 + 12'(i * 4) + (h ? 12'h100 : 12'h000);
	endfunction
	// expected counts follow the events the core side really presented
	always @(posedge clk_sys_i)
	begin
		hl = ev.halted_by_halt_instruction | ev.halted_by_monitor_wait_instruction;
		if (nrst_i === 1'b1)
		begin
			m[0] = m[0] + (ev.inst_retire & men[0]);
			m[1] = m[1] + (!hl & men[1]);
			m[2] = m[2] + (ev.ref_tick & !hl & !ev.thermal_monitor_stop_clk & men[2]);
			m[3] = m[3] + (msel & gp_hit(mevt, mum, ev));
		end
	end
	task automatic tally_and_finish();
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk_sys_i);
			t++;
		end
		while (rdy !== 1'b1 && t < 20);
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
		if (t >= 20)
			fails++;
		@(posedge clk_sys_i);
	endtask
	task automatic rd64(input int i);
		logic [31:0] lo;
		apb(1'b0, ad(i, 1'b0), 32'h0);
		lo = rd;
		apb(1'b0, ad(i, 1'b1), 32'h0);
		got = {rd, lo};
	endtask
	task automatic wr64(input int i, input logic [63:0] v);
		apb(1'b1, ad(i, 1'b0), v[31:0]);
		apb(1'b1, ad(i, 1'b1), v[63:32]);
		m[i] = v;
	endtask
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		#2000000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		{nrst_i, psel, pen, pwr, act, msel} = 6'h0;
		{padr, rnd, pwd, mevt, mum} = 72'h0;
		lfsr = 16'hff8f;
		fails = 0;
		n_checks = 0;
		m = '{default: 64'h0};
		men = 3'h7;
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		apb(1'b0, 12'he00, 32'h0);
		chk(64'(rd), 64'h7);
		apb(1'b0, 12'h000, 32'h0);
		chk({31'h0, er, rd}, 64'h1_0000_0000);
		apb(1'b1, 12'h004, 32'hffff_ffff);
		for (int k = 0; k < 8; k++)
		begin
			{mevt, mum} = tbl[k];
			apb(1'b1, 12'he04, {9'h0, 1'b1, 6'h0, mum, mevt});
			msel = 1'b1;
			apb(1'b0, 12'he04, 32'h0);
			chk(64'(rd), {41'h0, 1'b1, 6'h0, mum, mevt});
			lfsr = nx(lfsr);
			apb(1'b1, 12'he00, {29'h0, lfsr[2:0]});
			men = lfsr[2:0];
			apb(1'b0, 12'he00, 32'h0);
			chk(64'(rd), 64'(men));
			// low words start near the top so the high word can carry
			for (int i = 0; i < 4; i++)
				wr64(i, {28'h0, 4'(k), 32'hffff_ffc0});
			act <= 1'b1;
			repeat (300)
			begin
				lfsr = nx(lfsr);
				rnd <= lfsr[11:0];
				@(posedge clk_sys_i);
			end
			act <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
			for (int i = 0; i < 3; i++)
			begin
				rd64(i);
				chk(got, m[i]);
			end
			rd64(3);
			chk(got, m[3]);
		end
		// second reset in mid-run: every register must return to its reset value
		nrst_i <= 1'b0;
		m = '{default: 64'h0};
		men = 3'h7;
		msel = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		apb(1'b0, 12'he00, 32'h0);
		chk(64'(rd), 64'h7);
		apb(1'b0, 12'he04, 32'h0);
		chk(64'(rd), 64'h0);
		for (int i = 0; i < 4; i++)
		begin
			rd64(i);
			chk(got, m[i]);
		end
		tally_and_finish();
	end
endmodule // performance_event_counters_bench
`default_nettype wire
